/* include/tpalu_pkg.sv */
// Operation
// - a five-bit code picks the operation, zeros for OR, 11000 for add.
// - a nonzero condition selector sets both control bits to the condition's truth.
// - logical operations pass control bits and A sign, Y sign is zero; only conditions change control bits.
// - OR, AND and XOR combine A and B data bitwise onto X data.
// - and-with-complement inverts A data, ANDs it with B data, outputs X.
// - complement inverts A data onto X and ignores the B side.
// - arithmetic is 17-bit signed; selector 000 copies A and B control bits.
// - add and subtract give X result, Y zero, or plus/minus one on overflow.
// - multiply forms a 33-bit product, upper half to X, lower to Y.
// - pass-through copies A and B to X and Y, conditions still apply.
// - zero-count variants output the leading zero count of X data on Y.
// - add and subtract with count replace Y by plus/minus one on overflow.
// - multiply with count drops the low half, Y is count, Y sign zero.
// - increment and decrement change A by one; Y flags overflow like add.
// - barrel shift A data by B data bits 4:0, direction by opcode, reversed by B sign.
// - reversed shifts reverse A data bit order before the normal shift.
package tpalu_pkg;
	// ==========================================================
	// operation codes
	typedef enum logic [4:0] {
		TPALU_OR_OP          = 5'h00,
		TPALU_AND_OP         = 5'h01,
		TPALU_XOR_OP         = 5'h02,
		TPALU_ANDC_OP        = 5'h03,
		TPALU_NOT_OP         = 5'h0C,
		TPALU_ADD_OP         = 5'h18,
		TPALU_ADD_ZC_OP      = 5'h1C,
		TPALU_SUB_OP         = 5'h19,
		TPALU_SUB_ZC_OP      = 5'h1D,
		TPALU_MUL_OP         = 5'h1A,
		TPALU_MUL_ZC_OP      = 5'h1E,
		TPALU_PASS_OP        = 5'h1B,
		TPALU_PASS_ZC_OP     = 5'h1F,
		TPALU_INC_OP         = 5'h0A,
		TPALU_DEC_OP         = 5'h0B,
		TPALU_LEFT_OP        = 5'h04,
		TPALU_REV_LEFT_OP    = 5'h05,
		TPALU_RIGHT_OP       = 5'h06,
		TPALU_REV_RIGHT_OP   = 5'h07
	} tpalu_op_t;

	// ==========================================================
	// condition selector codes
	localparam logic [2:0]  TPALU_COND_NONE = 3'h0;
	localparam logic [2:0]  TPALU_COND_EQ   = 3'h1;
	localparam logic [2:0]  TPALU_COND_LT   = 3'h2;
	localparam logic [2:0]  TPALU_COND_LE   = 3'h3;
	localparam logic [2:0]  TPALU_COND_GT   = 3'h4;
	localparam logic [2:0]  TPALU_COND_GE   = 3'h5;
	localparam logic [2:0]  TPALU_COND_NE   = 3'h6;
	localparam logic [2:0]  TPALU_COND_OVF  = 3'h7;

	// ==========================================================
	// data constants and reset values
	localparam logic [15:0] TPALU_DATA_ZERO = 16'h0000;
	localparam logic [15:0] TPALU_DATA_ONE  = 16'h0001;
	localparam logic [15:0] TPALU_DATA_MONE = 16'hFFFF;
	localparam logic [15:0] TPALU_RST_DATA  = 16'h0000;
	localparam logic        TPALU_RST_BIT   = 1'b0;
	localparam int          TPALU_SHAMT_MSB = 4;
endpackage

/* rtl/tpalu_lzc.sv */
`timescale 1ns/10ps
// leading zero counter, all-zero word counts as 16
module tpalu_lzc (
	input  wire logic [15:0] data,
	output logic      [4:0]  count
);
	// scan from lsb so the highest set bit wins last
	always_comb begin
		count = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (data[i]) begin
				count = 5'(15 - i);
			end
		end
	end
endmodule

/* rtl/tpalu_core.sv */
`timescale 1ns/10ps
module tpalu_core
	import tpalu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [4:0]  opcode,
	input  wire logic [2:0]  condition_selector,
	input  wire logic        a_ctrl,
	input  wire logic        a_sign,
	input  wire logic [15:0] a_data,
	input  wire logic        b_ctrl,
	input  wire logic        b_sign,
	input  wire logic [15:0] b_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic             x_ctrl,
	output logic             x_sign,
	output logic [15:0]      x_data,
	output logic             y_ctrl,
	output logic             y_sign,
	output logic [15:0]      y_data,
	output logic             overflow
);
	// ==========================================================
	// arithmetic operands
	logic signed [17:0] a_ext;
	logic signed [17:0] b_ext;
	logic signed [17:0] sum;
	logic signed [17:0] diff;
	logic signed [17:0] incv;
	logic signed [17:0] decv;
	logic signed [16:0] a_s;
	logic signed [16:0] b_s;
	logic signed [33:0] prod;
	logic [15:0]        a_rev;
	logic [15:0]        sh_src;
	logic [15:0]        sh_res;
	logic               sh_right;
	logic [4:0]         lz_cnt;

	// sign-extend to 18 bits so the carry out shows range errors
	assign a_ext = {a_sign, a_sign, a_data};
	assign b_ext = {b_sign, b_sign, b_data};
	assign sum   = a_ext + b_ext;
	assign diff  = a_ext - b_ext;
	assign incv  = a_ext + 18'sd1;
	assign decv  = a_ext - 18'sd1;
	assign a_s   = {a_sign, a_data};
	assign b_s   = {b_sign, b_data};
	assign prod  = 34'(a_s) * 34'(b_s);

	// ==========================================================
	// barrel shifter
	always_comb begin
		a_rev = TPALU_DATA_ZERO;
		for (int i = 0; i < 16; i++) begin
			a_rev[i] = a_data[15 - i];
		end
	end

	// negative b sign turns the shift the other way
	assign sh_right = (opcode == TPALU_RIGHT_OP || opcode == TPALU_REV_RIGHT_OP) ^ b_sign;
	assign sh_src   = (opcode == TPALU_REV_LEFT_OP || opcode == TPALU_REV_RIGHT_OP) ?
			a_rev : a_data;
	// counts of 16 and above shift everything out, zeros fill in
	assign sh_res   = sh_right ? (sh_src >> b_data[TPALU_SHAMT_MSB:0]) :
			(sh_src << b_data[TPALU_SHAMT_MSB:0]);

	// ==========================================================
	// result selection
	logic        r_xc;
	logic        r_xs;
	logic [15:0] r_xd;
	logic        r_yc;
	logic        r_ys;
	logic [15:0] r_yd;
	logic        r_ovf;
	logic        r_unf;
	logic        r_arith;
	logic        r_zc;
	logic        c_true;
	logic [17:0] r_val;
	logic        f_ys;
	logic [15:0] f_yd;

	tpalu_lzc u_lzc (
		.data  (r_xd),
		.count (lz_cnt)
	);

	always_comb begin
		r_xc    = a_ctrl;
		r_yc    = b_ctrl;
		r_xs    = a_sign;
		r_xd    = a_data;
		r_ys    = TPALU_RST_BIT;
		r_yd    = TPALU_DATA_ZERO;
		r_val   = 18'h00000;
		r_arith = 1'b0;
		r_zc    = 1'b0;
		case (opcode)
			TPALU_OR_OP: begin
				r_xd = a_data | b_data;
			end
			TPALU_AND_OP: begin
				r_xd = a_data & b_data;
			end
			TPALU_XOR_OP: begin
				r_xd = a_data ^ b_data;
			end
			TPALU_ANDC_OP: begin
				r_xd = ~a_data & b_data;
			end
			TPALU_NOT_OP: begin
				r_xd = ~a_data;
			end
			TPALU_ADD_OP, TPALU_ADD_ZC_OP: begin
				r_val   = sum;
				r_arith = 1'b1;
				r_zc    = (opcode == TPALU_ADD_ZC_OP);
			end
			TPALU_SUB_OP, TPALU_SUB_ZC_OP: begin
				r_val   = diff;
				r_arith = 1'b1;
				r_zc    = (opcode == TPALU_SUB_ZC_OP);
			end
			TPALU_INC_OP: begin
				r_val   = incv;
				r_arith = 1'b1;
			end
			TPALU_DEC_OP: begin
				r_val   = decv;
				r_arith = 1'b1;
			end
			TPALU_MUL_OP: begin
				r_xs = prod[32];
				r_xd = prod[31:16];
				r_ys = prod[32];
				r_yd = prod[15:0];
			end
			TPALU_MUL_ZC_OP: begin
				r_xs = prod[32];
				r_xd = prod[31:16];
				r_ys = TPALU_RST_BIT;
				r_zc = 1'b1;
			end
			TPALU_PASS_ZC_OP: begin
				r_zc = 1'b1;
			end
			TPALU_LEFT_OP, TPALU_RIGHT_OP, TPALU_REV_LEFT_OP, TPALU_REV_RIGHT_OP: begin
				r_xd = sh_res;
			end
			TPALU_PASS_OP: begin
				r_ys = b_sign;
				r_yd = b_data;
			end
			default: begin
				// unhandled codes behave as pass-through
				r_ys = b_sign;
				r_yd = b_data;
			end
		endcase
		// 18-bit value out of 17-bit signed range
		r_ovf = r_arith && (r_val[17:16] == 2'b01);
		r_unf = r_arith && (r_val[17:16] == 2'b10);
		if (r_arith) begin
			r_xs = r_val[16];
			r_xd = r_val[15:0];
		end
	end

	// ==========================================================
	// final y word
	// kept apart so the zero counter never feeds the process that drives it
	always_comb begin
		f_ys = r_ys;
		f_yd = r_yd;
		if (r_zc) begin
			f_ys = TPALU_RST_BIT;
			f_yd = {11'h000, lz_cnt};
		end
		if (r_ovf) begin
			f_ys = 1'b0;
			f_yd = TPALU_DATA_ONE;
		end else if (r_unf) begin
			f_ys = 1'b1;
			f_yd = TPALU_DATA_MONE;
		end
	end

	// ==========================================================
	// condition test on the X result
	always_comb begin
		case (condition_selector)
			TPALU_COND_EQ:  c_true = ~r_xs && (r_xd == TPALU_DATA_ZERO);
			TPALU_COND_LT:  c_true = r_xs;
			TPALU_COND_LE:  c_true = r_xs || (r_xd == TPALU_DATA_ZERO);
			TPALU_COND_GT:  c_true = ~r_xs && (r_xd != TPALU_DATA_ZERO);
			TPALU_COND_GE:  c_true = ~r_xs;
			TPALU_COND_NE:  c_true = r_xs || (r_xd != TPALU_DATA_ZERO);
			TPALU_COND_OVF: c_true = r_ovf || r_unf;
			default:        c_true = 1'b0;
		endcase
	end

	// ==========================================================
	// output token register, one stage
	logic        vld_q, vld_d;
	logic        xc_q, xc_d;
	logic        xs_q, xs_d;
	logic [15:0] xd_q, xd_d;
	logic        yc_q, yc_d;
	logic        ys_q, ys_d;
	logic [15:0] yd_q, yd_d;
	logic        ovf_q, ovf_d;
	logic        take;

	// a held token blocks the next until the formatter accepts it
	assign in_ready = out_ready || !vld_q;
	assign take     = in_valid && in_ready;

	always_comb begin
		vld_d = vld_q;
		xc_d  = xc_q;
		xs_d  = xs_q;
		xd_d  = xd_q;
		yc_d  = yc_q;
		ys_d  = ys_q;
		yd_d  = yd_q;
		ovf_d = ovf_q;
		if (out_ready && vld_q) begin
			vld_d = 1'b0;
		end
		if (take) begin
			vld_d = 1'b1;
			xs_d  = r_xs;
			xd_d  = r_xd;
			ys_d  = f_ys;
			yd_d  = f_yd;
			ovf_d = r_ovf || r_unf;
			if (condition_selector != TPALU_COND_NONE) begin
				xc_d = c_true;
				yc_d = c_true;
			end else begin
				xc_d = r_xc;
				yc_d = r_yc;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vld_q <= TPALU_RST_BIT;
			xc_q  <= TPALU_RST_BIT;
			xs_q  <= TPALU_RST_BIT;
			xd_q  <= TPALU_RST_DATA;
			yc_q  <= TPALU_RST_BIT;
			ys_q  <= TPALU_RST_BIT;
			yd_q  <= TPALU_RST_DATA;
			ovf_q <= TPALU_RST_BIT;
		end else begin
			vld_q <= vld_d;
			xc_q  <= xc_d;
			xs_q  <= xs_d;
			xd_q  <= xd_d;
			yc_q  <= yc_d;
			ys_q  <= ys_d;
			yd_q  <= yd_d;
			ovf_q <= ovf_d;
		end
	end

	assign out_valid = vld_q;
	assign x_ctrl    = xc_q;
	assign x_sign    = xs_q;
	assign x_data    = xd_q;
	assign y_ctrl    = yc_q;
	assign y_sign    = ys_q;
	assign y_data    = yd_q;
	assign overflow  = ovf_q;
endmodule

/* testbench/tpalu_core_assertions.sv */
`timescale 1ns/10ps
// ==========
// port-level checks of the datapath core
module tpalu_core_assertions
	import tpalu_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [4:0]  opcode,
	input wire logic [2:0]  condition_selector,
	input wire logic        a_ctrl,
	input wire logic        a_sign,
	input wire logic [15:0] a_data,
	input wire logic        b_ctrl,
	input wire logic        b_sign,
	input wire logic [15:0] b_data,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic        x_ctrl,
	input wire logic        x_sign,
	input wire logic [15:0] x_data,
	input wire logic        y_ctrl,
	input wire logic        y_sign,
	input wire logic [15:0] y_data,
	input wire logic        overflow
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic take;
	// a token enters on every edge with both handshake lines high
	assign take = in_valid && in_ready;
	a_answer_next: assert property (take |=> out_valid) else $error("no result");
	a_or_word: assert property (take && opcode == 5'h00 |=> x_data == $past(a_data | b_data))
		else $error("or word wrong");
	a_andc_word: assert property (take && opcode == 5'h03 |=> x_data == $past(~a_data & b_data))
		else $error("andc word wrong");
	a_not_word: assert property (take && opcode == 5'h0C |=> x_data == ~$past(a_data)
		&& y_data == 16'h0000 && !y_sign) else $error("not word wrong");
	a_logic_bits: assert property (take && opcode[4:2] == 3'h0 && condition_selector == 3'h0
		|=> x_sign == $past(a_sign) && x_ctrl == $past(a_ctrl) && y_ctrl == $past(b_ctrl))
		else $error("logic bits wrong");
	a_arith_ctrl: assert property (take && opcode[4:3] == 2'h3 && condition_selector == 3'h0
		|=> x_ctrl == $past(a_ctrl) && y_ctrl == $past(b_ctrl))
		else $error("ctrl copy wrong");
	a_cond_pair: assert property (take && condition_selector != 3'h0 |=> x_ctrl == y_ctrl)
		else $error("ctrl pair differs");
	a_zero_cond: assert property (take && condition_selector == 3'h1
		|=> x_ctrl == ({x_sign, x_data} == 17'h00000)) else $error("zero test wrong");
	a_mul_sign: assert property (take && opcode == 5'h1A |=> y_sign == x_sign && !overflow)
		else $error("mul sign wrong");
	a_mulzc_sign: assert property (take && opcode == 5'h1E |=> !y_sign)
		else $error("mulzc sign set");
	a_flag_y: assert property (out_valid && overflow |-> (y_data == 16'h0001 && !y_sign)
		|| (y_data == 16'hFFFF && y_sign)) else $error("flag word wrong");
endmodule
bind tpalu_core tpalu_core_assertions i_tpalu_core_assertions (.*);

/* testbench/tpalu_sink.sv */
`timescale 1ns/10ps
// ==========
// formatter side: takes results, stalls at random when allowed
module tpalu_sink (
	input  wire logic clk,
	input  wire logic stall_en,
	output logic      out_ready
);
	// back-pressure changes just after each edge so the core sees a settled level
	initial begin
		out_ready = 1'b1;
		forever begin
			@(posedge clk);
			#1 out_ready = !(stall_en && ($urandom % 3 == 0));
		end
	end
endmodule

/* testbench/tpalu_core_tb.sv */
`timescale 1ns/10ps
module tpalu_core_tb
	import tpalu_pkg::*;
;
	logic        clk = 1'b0, sys_rst = 1'b1, in_valid = 1'b0, stall_en = 1'b0;
	logic [4:0]  opcode = 5'h00;
	logic [2:0]  condition_selector = 3'h0;
	logic        a_ctrl = 1'b0, a_sign = 1'b0, b_ctrl = 1'b0, b_sign = 1'b0;
	logic [15:0] a_data = 16'h0000, b_data = 16'h0000, x_data, y_data;
	logic        in_ready, out_valid, out_ready, x_ctrl, x_sign, y_ctrl, y_sign, overflow;
	logic [36:0] exp_q[$];
	logic [4:0]  ops[20] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0C, 5'h18, 5'h1C, 5'h19, 5'h1D,
		5'h1A, 5'h1E, 5'h1B, 5'h1F, 5'h0A, 5'h0B, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08};
	int          err_count = 0, samples_checked = 0, cyc = 0;
	tpalu_core i_tpalu_core (.*);
	tpalu_sink i_tpalu_sink (.clk(clk), .stall_en(stall_en), .out_ready(out_ready));
	// ==========
	// reference model
	function automatic logic [4:0] lz(logic [15:0] d);
		lz = 5'h10;
		for (int i = 0; i < 16; i++)
			if (d[i]) lz = 5'(15 - i);
	endfunction
	function automatic logic [36:0] model(logic [4:0] op, logic [2:0] cs, logic ac, logic as,
		logic [15:0] ad, logic bc, logic bs, logic [15:0] bd);
		logic [17:0] r;
		logic [32:0] p;
		logic [15:0] s;
		logic [16:0] x, y;
		logic        v, u, t;
		{v, u, x, y} = {2'h0, as, ad, bs, bd};
		case (op)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h0C: begin
				s = op == 5'h0C ? ~ad : op == 5'h03 ? ~ad & bd : op == 5'h02 ? ad ^ bd
					: op == 5'h01 ? ad & bd : ad | bd;
				{x, y} = {as, s, 17'h0};
			end
			5'h04, 5'h05, 5'h06, 5'h07: begin
				for (int i = 0; i < 16; i++)
					s[i] = op[0] ? ad[15 - i] : ad[i];
				s = (op[1] ^ bs) ? s >> bd[4:0] : s << bd[4:0];
				{x, y} = {as, s, 17'h0};
			end
			5'h18, 5'h1C, 5'h19, 5'h1D, 5'h0A, 5'h0B: begin
				r = op[4] ? {bs, bs, bd} : 18'h1;
				r = op[0] ? {as, as, ad} - r : {as, as, ad} + r;
				{v, u, x} = {r[17:16] == 2'h1, r[17:16] == 2'h2, r[16:0]};
				y = v ? 17'h00001 : u ? 17'h1FFFF : op[2] ? {12'h0, lz(r[15:0])} : 17'h0;
			end
			5'h1A, 5'h1E: begin
				p = $signed({as, ad}) * $signed({bs, bd});
				x = p[32:16];
				y = op[2] ? {12'h0, lz(p[31:16])} : {p[32], p[15:0]};
			end
			5'h1F: y = {12'h0, lz(ad)};
			default: ;
		endcase
		case (cs)
			3'h1: t = x == 17'h0;
			3'h2: t = x[16];
			3'h3: t = x[16] || x == 17'h0;
			3'h4: t = !x[16] && x != 17'h0;
			3'h5: t = !x[16];
			3'h6: t = x != 17'h0;
			default: t = v || u;
		endcase
		model = cs == 3'h0 ? {ac, x, bc, y, v | u} : {t, x, t, y, v | u};
	endfunction
	function automatic logic [15:0] pick();
		logic [15:0] c[4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h0001};
		pick = ($urandom % 2) ? 16'($urandom) : c[$urandom % 4];
	endfunction
	// ==========
	// drive, compare, report
	task automatic cmp(logic [37:0] got, logic [37:0] e);
		samples_checked++;
		if (got !== e) begin
			err_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// holds the token until an edge sees in_ready, so back-to-back stays possible
	task automatic send(logic [4:0] op, logic [2:0] cs, logic [15:0] ad, logic [15:0] bd);
		#1 {opcode, condition_selector, a_data, b_data} = {op, cs, ad, bd};
		{a_ctrl, a_sign, b_ctrl, b_sign} = 4'($urandom);
		in_valid = 1'b1;
		@(posedge clk);
		while (in_ready !== 1'b1) @(posedge clk);
	endtask
	initial forever #2 clk = ~clk;
	// scoreboard: push at each take, compare at each accepted result
	always @(posedge clk) begin
		cyc++;
		if (!sys_rst && out_valid && out_ready)
			cmp({1'b1, x_ctrl, x_sign, x_data, y_ctrl, y_sign, y_data, overflow},
				{1'b1, exp_q.pop_front()});
		if (!sys_rst && in_valid && in_ready)
			exp_q.push_back(model(opcode, condition_selector, a_ctrl, a_sign, a_data,
				b_ctrl, b_sign, b_data));
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(41426));
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (int k = 0; k < 3000; k++) begin
			stall_en = k >= 800;
			send(ops[$urandom % 20], 3'($urandom), pick(), pick());
			if (k == 2000) begin
				#1 {in_valid, sys_rst} = 2'h1;
				@(posedge clk);
				cmp({out_valid | !in_ready, x_ctrl, x_sign, x_data, y_ctrl, y_sign, y_data,
					overflow}, 38'h0);
				@(posedge clk);
				exp_q.delete();
				#1 sys_rst = 1'b0;
			end
			if ($urandom % 4 == 0) begin
				#1 in_valid = 1'b0;
				@(posedge clk);
			end
		end
		#1 {in_valid, stall_en} = 2'h0;
		repeat (20) @(posedge clk);
		cmp(38'(exp_q.size()), 38'h0);
		print_verdict();
	end
endmodule
